// file: include/psw_consts.vh
`ifndef PSW_CONSTS_VH
`define PSW_CONSTS_VH

// ****************************************
// geometry
// ****************************************
`define PSW_PORTS        16
`define PSW_CTRS         5
`define PSW_ADDR_W       18
`define PSW_PEND_W       8

// ****************************************
// register index map (byte address = 4 * index)
// ****************************************
`define PSW_PORT0_BASE   16'h2400
`define PSW_PORT_STRIDE  16'h0400
`define PSW_PORT_FIRST   6'h09
`define PSW_PORT_LAST    6'h18
`define PSW_HOST_BLOCK   6'h19
`define PSW_OFS_MEDIA    10'h000
`define PSW_OFS_IOEN     10'h004
`define PSW_OFS_RX_GOOD  10'h010
`define PSW_OFS_RX_BAD   10'h014
`define PSW_OFS_RX_DROP  10'h01b
`define PSW_OFS_TX_GOOD  10'h01f
`define PSW_OFS_TX_BAD   10'h020
`define PSW_OFS_LEN_LO   10'h000
`define PSW_OFS_LEN_HI   10'h001
`define PSW_OFS_RD_RES   10'h002
`define PSW_OFS_SRC_PORT 10'h003
`define PSW_OFS_HPE      10'h004
`define PSW_OFS_WR_RES   10'h010

// ****************************************
// fields and reset values
// ****************************************
`define PSW_MEDIA_RST    4'h0
`define PSW_IOEN_RST     2'h0
`define PSW_HPE_RST      2'h0
`define PSW_RES_IDLE     2'h0
`define PSW_RES_OK       2'h1
`define PSW_RES_ERR      2'h2
`define PSW_BIT_SPEED    0
`define PSW_BIT_HALF     1
`define PSW_BIT_RXPAUSE  2
`define PSW_BIT_TXPAUSE  3
`define PSW_BIT_IN_EN    0
`define PSW_BIT_OUT_EN   1
`define PSW_MIN_FRAME    11'h040
`define PSW_MAX_FRAME    11'h5f2

`endif

// file: hw/psw_stat_ctr.v
`timescale 1ns/1ps
`include "psw_consts.vh"

module psw_stat_ctr (
    input  wire        i_sys_clk,
    input  wire        i_rst_n,
    input  wire        i_event,
    input  wire        i_freeze,
    output wire [31:0] o_count
);

    reg  [31:0]             count_r;
    reg  [`PSW_PEND_W-1:0]  pend_r;
    wire [31:0]             pend_ext;

    assign pend_ext = {{(32-`PSW_PEND_W){1'b0}}, pend_r};
    assign o_count  = count_r;

    // ****************************************
    // count with deferral
    // ****************************************
    // pending saturates; only a read train longer than 255 cycles could lose events
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            count_r <= 32'h0;
            pend_r  <= {`PSW_PEND_W{1'b0}};
        end else if (i_freeze) begin
            if (i_event && (pend_r != {`PSW_PEND_W{1'b1}})) begin
                pend_r <= pend_r + 1'b1;
            end
        end else begin
            count_r <= count_r + pend_ext + {31'h0, i_event};
            pend_r  <= {`PSW_PEND_W{1'b0}};
        end
    end

endmodule // psw_stat_ctr

// file: hw/psw_regs.v
`timescale 1ns/1ps
`include "psw_consts.vh"

module psw_regs (
    input  wire                  i_sys_clk,
    input  wire                  i_rst_n,
    // apb slave
    input  wire                  i_psel,
    input  wire                  i_penable,
    input  wire                  i_pwrite,
    input  wire [`PSW_ADDR_W-1:0] i_paddr,
    input  wire [31:0]           i_pwdata,
    output wire [31:0]           o_prdata,
    output wire                  o_pready,
    output wire                  o_pslverr,
    // per-port receive events
    input  wire [15:0]           i_rx_done,
    input  wire [15:0]           i_rx_crc_ok,
    input  wire [175:0]          i_rx_len,
    input  wire [15:0]           i_rx_overrun,
    // per-port transmit events
    input  wire [15:0]           i_tx_done,
    input  wire [15:0]           i_tx_collided,
    input  wire [15:0]           i_tx_col_retry,
    input  wire [15:0]           i_tx_underrun,
    // per-port controls
    output wire [15:0]           o_low_speed_select,
    output wire [15:0]           o_half_duplex_select,
    output wire [15:0]           o_rx_pause_disable,
    output wire [15:0]           o_tx_pause_disable,
    output wire [15:0]           o_port_rx_en,
    output wire [15:0]           o_port_tx_en,
    // host packet port
    input  wire [10:0]           i_host_rx_len,
    input  wire [3:0]            i_host_rx_port,
    input  wire                  i_host_rd_start,
    input  wire                  i_host_rd_ok,
    input  wire                  i_host_rd_err,
    input  wire                  i_host_wr_start,
    input  wire                  i_host_wr_ok,
    input  wire                  i_host_wr_err,
    input  wire                  i_host_wr_ready,
    output wire                  o_host_in_en,
    output wire                  o_host_out_en,
    output wire                  o_host_wr_ready
);

    // ****************************************
    // declarations
    // ****************************************
    reg  [63:0]  media_r;
    reg  [31:0]  ioen_r;
    reg  [1:0]   hpe_r;
    reg  [1:0]   rd_res_r;
    reg  [1:0]   wr_res_r;
    reg          wr_rdy_r;
    reg  [10:0]  rx_len_r;
    reg  [3:0]   rx_port_r;
    reg  [31:0]  prdata_r;
    reg  [31:0]  prdata_nxt;
    reg          slverr_r;
    reg          slverr_nxt;
    reg  [6:0]   cidx;
    reg          cidx_vld;

    wire [15:0]  idx;
    wire [9:0]   ofs;
    wire [5:0]   blk;
    wire [5:0]   port_num;
    wire [3:0]   port_sel;
    wire         port_hit;
    wire         host_hit;
    wire         setup_ph;
    wire         wr_en;
    wire         rd_act;
    wire [15:0]  rx_in_range;
    wire [15:0]  rx_good;
    wire [15:0]  rx_bad;
    wire [15:0]  tx_good;
    wire [15:0]  tx_bad;
    wire [79:0]  ctr_ev;
    wire [79:0]  ctr_frz;
    wire [2559:0] cnt_flat;

    // ****************************************
    // address decode
    // ****************************************
    // word index; byte lanes below it are ignored
    assign idx      = i_paddr[17:2];
    assign ofs      = idx[9:0];
    assign blk      = idx[15:10];
    assign port_num = blk - `PSW_PORT_FIRST;
    assign port_sel = port_num[3:0];
    assign port_hit = (blk >= `PSW_PORT_FIRST) && (blk <= `PSW_PORT_LAST);
    assign host_hit = (blk == `PSW_HOST_BLOCK);
    assign setup_ph = i_psel && !i_penable;
    assign wr_en    = i_psel && i_penable && i_pwrite;
    assign rd_act   = i_psel && !i_pwrite;

    // ****************************************
    // apb answer
    // ****************************************
    // no wait states: read data is fetched in the setup cycle
    assign o_pready  = 1'b1;
    assign o_prdata  = prdata_r;
    assign o_pslverr = slverr_r && i_psel && i_penable;

    // ****************************************
    // frame classification
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < `PSW_PORTS; g = g + 1) begin : g_cls
            wire [10:0] len;
            assign len = i_rx_len[g*11 +: 11];
            assign rx_in_range[g] = (len >= `PSW_MIN_FRAME) && (len <= `PSW_MAX_FRAME);
            assign rx_good[g] = i_rx_done[g] && i_rx_crc_ok[g] && rx_in_range[g];
            assign rx_bad[g]  = i_rx_done[g] && !(i_rx_crc_ok[g] && rx_in_range[g]);
            assign tx_good[g] = i_tx_done[g] && !i_tx_collided[g];
            assign tx_bad[g]  = i_tx_col_retry[g] || i_tx_underrun[g];
        end
    endgenerate

    // ****************************************
    // statistics counters
    // ****************************************
    genvar k;
    generate
        for (k = 0; k < 80; k = k + 1) begin : g_ctr
            localparam integer P = k / 5;
            localparam integer J = k % 5;
            localparam [9:0] CO = (J == 0) ? `PSW_OFS_RX_GOOD :
                                  (J == 1) ? `PSW_OFS_RX_BAD  :
                                  (J == 2) ? `PSW_OFS_RX_DROP :
                                  (J == 3) ? `PSW_OFS_TX_GOOD : `PSW_OFS_TX_BAD;
            assign ctr_ev[k] = (J == 0) ? rx_good[P] :
                               (J == 1) ? rx_bad[P]  :
                               (J == 2) ? i_rx_overrun[P] :
                               (J == 3) ? tx_good[P] : tx_bad[P];
            // held from setup through access of a read to this word
            assign ctr_frz[k] = rd_act && port_hit && (port_sel == P) && (ofs == CO);
            psw_stat_ctr u_ctr (
                .i_sys_clk (i_sys_clk),
                .i_rst_n   (i_rst_n),
                .i_event   (ctr_ev[k]),
                .i_freeze  (ctr_frz[k]),
                .o_count   (cnt_flat[k*32 +: 32])
            );
        end
    endgenerate

    // ****************************************
    // per-port control registers
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            media_r <= {16{`PSW_MEDIA_RST}};
            ioen_r  <= {16{`PSW_IOEN_RST}};
        end else if (wr_en && port_hit) begin
            if (ofs == `PSW_OFS_MEDIA) begin
                media_r[{port_sel, 2'b00} +: 4] <= i_pwdata[3:0];
            end
            if (ofs == `PSW_OFS_IOEN) begin
                ioen_r[{port_sel, 1'b0} +: 2] <= i_pwdata[1:0];
            end
        end
    end

    generate
        for (g = 0; g < `PSW_PORTS; g = g + 1) begin : g_out
            assign o_low_speed_select[g]   = media_r[g*4 + `PSW_BIT_SPEED];
            assign o_half_duplex_select[g] = media_r[g*4 + `PSW_BIT_HALF];
            assign o_rx_pause_disable[g]   = media_r[g*4 + `PSW_BIT_RXPAUSE];
            assign o_tx_pause_disable[g]   = media_r[g*4 + `PSW_BIT_TXPAUSE];
            assign o_port_rx_en[g]         = ioen_r[g*2 + `PSW_BIT_IN_EN];
            assign o_port_tx_en[g]         = ioen_r[g*2 + `PSW_BIT_OUT_EN];
        end
    endgenerate

    // ****************************************
    // host packet port registers
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            hpe_r <= `PSW_HPE_RST;
        end else if (wr_en && host_hit && (ofs == `PSW_OFS_HPE)) begin
            hpe_r <= i_pwdata[1:0];
        end
    end

    assign o_host_in_en    = hpe_r[`PSW_BIT_IN_EN];
    assign o_host_out_en   = hpe_r[`PSW_BIT_OUT_EN];
    assign o_host_wr_ready = wr_rdy_r;

    // result events beat a same-cycle start
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            rd_res_r <= `PSW_RES_IDLE;
        end else if (i_host_rd_ok) begin
            rd_res_r <= `PSW_RES_OK;
        end else if (i_host_rd_err) begin
            rd_res_r <= `PSW_RES_ERR;
        end else if (i_host_rd_start) begin
            rd_res_r <= `PSW_RES_IDLE;
        end
    end

    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_res_r <= `PSW_RES_IDLE;
        end else if (i_host_wr_ok) begin
            wr_res_r <= `PSW_RES_OK;
        end else if (i_host_wr_err) begin
            wr_res_r <= `PSW_RES_ERR;
        end else if (i_host_wr_start) begin
            wr_res_r <= `PSW_RES_IDLE;
        end
    end

    // length and source follow the head of the host queue
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            wr_rdy_r  <= 1'b0;
            rx_len_r  <= 11'h0;
            rx_port_r <= 4'h0;
        end else begin
            wr_rdy_r  <= i_host_wr_ready && hpe_r[`PSW_BIT_IN_EN];
            rx_len_r  <= i_host_rx_len;
            rx_port_r <= i_host_rx_port;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    always @* begin
        cidx_vld = 1'b1;
        cidx     = {3'h0, port_sel} * 7'h05;
        case (ofs)
            `PSW_OFS_RX_GOOD: cidx = cidx + 7'h00;
            `PSW_OFS_RX_BAD:  cidx = cidx + 7'h01;
            `PSW_OFS_RX_DROP: cidx = cidx + 7'h02;
            `PSW_OFS_TX_GOOD: cidx = cidx + 7'h03;
            `PSW_OFS_TX_BAD:  cidx = cidx + 7'h04;
            default:          cidx_vld = 1'b0;
        endcase
    end

    always @* begin
        prdata_nxt = 32'h0;
        slverr_nxt = 1'b0;
        if (port_hit) begin
            if (ofs == `PSW_OFS_MEDIA) begin
                prdata_nxt = {28'h0, media_r[{port_sel, 2'b00} +: 4]};
            end else if (ofs == `PSW_OFS_IOEN) begin
                prdata_nxt = {30'h0, ioen_r[{port_sel, 1'b0} +: 2]};
            end else if (cidx_vld) begin
                prdata_nxt = cnt_flat[{cidx, 5'h00} +: 32];
            end else begin
                slverr_nxt = 1'b1;
            end
        end else if (host_hit) begin
            case (ofs)
                `PSW_OFS_LEN_LO:   prdata_nxt = {24'h0, rx_len_r[7:0]};
                `PSW_OFS_LEN_HI:   prdata_nxt = {29'h0, rx_len_r[10:8]};
                `PSW_OFS_RD_RES:   prdata_nxt = {30'h0, rd_res_r};
                `PSW_OFS_SRC_PORT: prdata_nxt = {28'h0, rx_port_r};
                `PSW_OFS_HPE:      prdata_nxt = {30'h0, hpe_r};
                `PSW_OFS_WR_RES:   prdata_nxt = {29'h0, wr_rdy_r, wr_res_r};
                default:           slverr_nxt = 1'b1;
            endcase
        end else begin
            slverr_nxt = 1'b1;
        end
    end

    // snapshot in setup; the frozen counter keeps it whole for the access
    always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            prdata_r <= 32'h0;
            slverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= i_pwrite ? 32'h0 : prdata_nxt;
            slverr_r <= slverr_nxt;
        end
    end

endmodule // psw_regs

// file: test/psw_regs_props.sv
`timescale 1ns/1ps
`include "psw_consts.vh"

// ****************************************
// apb and control checks
// ****************************************
module psw_regs_props (
    input wire        i_sys_clk,
    input wire        i_rst_n,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [17:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire [15:0] o_low_speed_select,
    input wire [15:0] o_port_rx_en,
    input wire [15:0] o_port_tx_en,
    input wire        i_host_wr_ready,
    input wire        o_host_in_en,
    input wire        o_host_out_en,
    input wire        o_host_wr_ready
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire setup  = i_psel && !i_penable;
    wire wr_acc = i_psel && i_penable && i_pwrite;
    // no wait states, so a master never stalls
    no_wait_a: assert property (o_pready) else $error("pready low");
    err_phase_a: assert property (o_pslverr |-> i_psel && i_penable) else $error("stray pslverr");
    unmapped_err_a: assert property (setup && i_paddr < 18'h09000 |=> o_pslverr && o_prdata == 32'h0)
        else $error("unmapped access not refused");
    rdata_hold_a: assert property (setup |-> ##2 $stable(o_prdata)) else $error("prdata moved");
    wr_zero_a: assert property (setup && i_pwrite |=> o_prdata == 32'h0) else $error("write data echoed");
    ioen_write_a: assert property (wr_acc && i_paddr == 18'h09010 |=>
        o_port_rx_en[0] == $past(i_pwdata[0]) && o_port_tx_en[0] == $past(i_pwdata[1]))
        else $error("io enable not updated");
    speed_hold_a: assert property (!wr_acc |=> $stable(o_low_speed_select)) else $error("speed moved");
    host_en_write_a: assert property (wr_acc && i_paddr == 18'h19010 |=>
        o_host_in_en == $past(i_pwdata[0]) && o_host_out_en == $past(i_pwdata[1]))
        else $error("host enable not updated");
    wr_ready_a: assert property (o_host_wr_ready == $past(i_host_wr_ready && o_host_in_en))
        else $error("write ready wrong");
endmodule // psw_regs_props

bind psw_regs psw_regs_props u_props (.i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_low_speed_select, .o_port_rx_en, .o_port_tx_en,
    .i_host_wr_ready, .o_host_in_en, .o_host_out_en, .o_host_wr_ready);

// file: test/psw_regs_tb_top.sv
`timescale 1ns/1ps
`include "psw_consts.vh"

// ****************************************
// bench
// ****************************************
module psw_regs_tb_top;
    logic         i_sys_clk, i_rst_n, i_psel, i_penable, i_pwrite, rerr, i_host_wr_ready;
    logic         i_host_rd_start, i_host_rd_ok, i_host_rd_err, i_host_wr_start, i_host_wr_ok, i_host_wr_err;
    logic [17:0]  i_paddr;
    logic [31:0]  i_pwdata, rdat;
    logic [15:0]  i_rx_done, i_rx_crc_ok, i_rx_overrun, i_tx_done, i_tx_collided, i_tx_col_retry, i_tx_underrun;
    logic [175:0] i_rx_len;
    logic [10:0]  i_host_rx_len;
    logic [3:0]   i_host_rx_port;
    wire  [31:0]  o_prdata;
    wire          o_pready, o_pslverr, o_host_in_en, o_host_out_en, o_host_wr_ready;
    wire  [15:0]  o_low_speed_select, o_half_duplex_select, o_rx_pause_disable, o_tx_pause_disable;
    wire  [15:0]  o_port_rx_en, o_port_tx_en;
    int           fail_count, check_count;

    psw_regs dut (.i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
        .o_pready, .o_pslverr, .i_rx_done, .i_rx_crc_ok, .i_rx_len, .i_rx_overrun, .i_tx_done,
        .i_tx_collided, .i_tx_col_retry, .i_tx_underrun, .o_low_speed_select, .o_half_duplex_select,
        .o_rx_pause_disable, .o_tx_pause_disable, .o_port_rx_en, .o_port_tx_en, .i_host_rx_len,
        .i_host_rx_port, .i_host_rd_start, .i_host_rd_ok, .i_host_rd_err, .i_host_wr_start,
        .i_host_wr_ok, .i_host_wr_err, .i_host_wr_ready, .o_host_in_en, .o_host_out_en, .o_host_wr_ready);

    task finish_test;
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task chk_data(input string n, input logic [31:0] x, input logic [31:0] g);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask

    task chk_flag(input string n, input logic x, input logic g);
        chk_data(n, {31'h0, x}, {31'h0, g});
    endtask

    // one idle cycle after each transfer keeps a driver from assigning twice per step
    task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int k;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_sys_clk);
            k++;
        end while (o_pready !== 1'b1 && k < 64);
        if (o_pready !== 1'b1) begin
            fail_count++;
            finish_test;
        end
        rdat = o_prdata;
        rerr = o_pslverr;
        {i_psel, i_penable} <= 2'b00;
        @(posedge i_sys_clk);
    endtask

    // host block sits where a seventeenth port would
    function logic [17:0] ad(input int p, input int o);
        return 18'((`PSW_PORT0_BASE + `PSW_PORT_STRIDE * p + o) * 4);
    endfunction

    function logic [31:0] res(input logic [2:0] c);
        return {30'h0, c[1] ? `PSW_RES_OK : c[2] ? `PSW_RES_ERR : `PSW_RES_IDLE};
    endfunction

    function int good(input logic [10:0] n, input logic ok);
        return int'(ok && n >= `PSW_MIN_FRAME && n <= `PSW_MAX_FRAME);
    endfunction

    task rx(input int p, input logic [10:0] n, input logic ok);
        i_rx_len[p*11 +: 11] <= n;
        {i_rx_done[p], i_rx_crc_ok[p]} <= {1'b1, ok};
        @(posedge i_sys_clk);
        {i_rx_done, i_rx_crc_ok} <= '0;
        @(posedge i_sys_clk);
    endtask

    task tx(input int p, input logic [4:0] v);
        {i_rx_overrun[p], i_tx_underrun[p], i_tx_col_retry[p], i_tx_collided[p], i_tx_done[p]} <= v;
        @(posedge i_sys_clk);
        {i_rx_overrun, i_tx_underrun, i_tx_col_retry, i_tx_collided, i_tx_done} <= '0;
        @(posedge i_sys_clk);
    endtask

    task hs(input logic r, input logic [2:0] c);
        if (r) {i_host_rd_err, i_host_rd_ok, i_host_rd_start} <= c;
        else {i_host_wr_err, i_host_wr_ok, i_host_wr_start} <= c;
        @(posedge i_sys_clk);
        {i_host_rd_err, i_host_rd_ok, i_host_rd_start, i_host_wr_err, i_host_wr_ok, i_host_wr_start} <= '0;
        @(posedge i_sys_clk);
    endtask

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    initial begin
        int p, eg, eb, ed, etg, etb;
        logic [31:0] v [16];
        logic [10:0] lens [5];
        int po [7] = '{0, 4, 'h10, 'h14, 'h1b, 'h1f, 'h20};
        int ho [6] = '{0, 1, 2, 3, 4, 'h10};
        logic [2:0] cs [4] = '{3'b010, 3'b100, 3'b001, 3'b100};
        {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_rx_len} = '0;
        {i_rx_done, i_rx_crc_ok, i_rx_overrun, i_tx_done, i_tx_collided, i_tx_col_retry, i_tx_underrun} = '0;
        {i_host_rx_len, i_host_rx_port, i_host_rd_start, i_host_rd_ok, i_host_rd_err} = '0;
        {i_host_wr_start, i_host_wr_ok, i_host_wr_err} = '0;
        i_host_wr_ready = 1'b1;
        fail_count = 0;
        check_count = 0;
        void'($urandom(32'hfa5d5713));
        repeat (12) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        foreach (po[i]) for (int k = 0; k < 16; k += 15) begin
            apb(1'b0, ad(k, po[i]), 32'h0);
            chk_data("port reset", 32'h0, rdat);
        end
        // ready stays low here although the input side is ready: host input still off
        foreach (ho[i]) begin
            apb(1'b0, ad(16, ho[i]), 32'h0);
            chk_data("host reset", 32'h0, rdat);
        end
        for (int k = 0; k < 16; k++) begin
            v[k] = $urandom;
            apb(1'b1, ad(k, `PSW_OFS_MEDIA), v[k]);
            apb(1'b1, ad(k, `PSW_OFS_IOEN), v[k] >> 4);
        end
        for (int k = 0; k < 16; k++) begin
            chk_flag("speed", v[k][`PSW_BIT_SPEED], o_low_speed_select[k]);
            chk_flag("duplex", v[k][`PSW_BIT_HALF], o_half_duplex_select[k]);
            chk_flag("rx pause", v[k][`PSW_BIT_RXPAUSE], o_rx_pause_disable[k]);
            chk_flag("tx pause", v[k][`PSW_BIT_TXPAUSE], o_tx_pause_disable[k]);
            chk_flag("rx en", v[k][4], o_port_rx_en[k]);
            chk_flag("tx en", v[k][5], o_port_tx_en[k]);
            apb(1'b0, ad(k, `PSW_OFS_MEDIA), 32'h0);
            chk_data("media", {28'h0, v[k][3:0]}, rdat);
            apb(1'b0, ad(k, `PSW_OFS_IOEN), 32'h0);
            chk_data("io enable", {30'h0, v[k][5:4]}, rdat);
        end
        for (int k = 0; k < 2; k++) begin
            p = k ? 15 : $urandom_range(14);
            {eg, eb, ed, etg, etb} = '0;
            lens = '{11'd63, 11'd64, 11'd1522, 11'd1523, 11'($urandom_range(2047))};
            foreach (lens[i]) for (int c = 0; c < 2; c++) begin
                rx(p, lens[i], c[0]);
                eg += good(lens[i], c[0]);
                eb += 1 - good(lens[i], c[0]);
            end
            // every mix of overrun, underrun, retry, collision and done
            for (int i = 0; i < 32; i++) begin
                tx(p, i[4:0]);
                ed += i[4];
                etg += i[0] & !i[1];
                etb += i[2] | i[3];
            end
            apb(1'b1, ad(p, `PSW_OFS_RX_GOOD), 32'hffffffff);
            apb(1'b0, ad(p, `PSW_OFS_RX_GOOD), 32'h0);
            chk_data("rx good", eg, rdat);
            apb(1'b0, ad(p, `PSW_OFS_RX_BAD), 32'h0);
            chk_data("rx bad", eb, rdat);
            apb(1'b0, ad(p, `PSW_OFS_RX_DROP), 32'h0);
            chk_data("drop", ed, rdat);
            apb(1'b0, ad(p, `PSW_OFS_TX_GOOD), 32'h0);
            chk_data("tx good", etg, rdat);
            apb(1'b0, ad(p, `PSW_OFS_TX_BAD), 32'h0);
            chk_data("tx bad", etb, rdat);
        end
        fork
            apb(1'b0, ad(p, `PSW_OFS_RX_GOOD), 32'h0);
            rx(p, 11'd64, 1'b1);
        join
        chk_data("frozen", eg, rdat);
        apb(1'b0, ad(p, `PSW_OFS_RX_GOOD), 32'h0);
        chk_data("deferred", eg + 1, rdat);
        i_host_rx_len <= 11'($urandom);
        i_host_rx_port <= 4'($urandom);
        repeat (2) @(posedge i_sys_clk);
        apb(1'b0, ad(16, `PSW_OFS_LEN_LO), 32'h0);
        chk_data("len low", {24'h0, i_host_rx_len[7:0]}, rdat);
        apb(1'b0, ad(16, `PSW_OFS_LEN_HI), 32'h0);
        chk_data("len high", {29'h0, i_host_rx_len[10:8]}, rdat);
        apb(1'b0, ad(16, `PSW_OFS_SRC_PORT), 32'h0);
        chk_data("src port", {28'h0, i_host_rx_port}, rdat);
        for (int r = 0; r < 2; r++) foreach (cs[i]) begin
            hs(r[0], cs[i]);
            apb(1'b0, ad(16, r ? `PSW_OFS_RD_RES : `PSW_OFS_WR_RES), 32'h0);
            chk_data("status", res(cs[i]), rdat);
        end
        apb(1'b1, ad(16, `PSW_OFS_HPE), 32'h1);
        chk_flag("host in", 1'b1, o_host_in_en);
        chk_flag("host out", 1'b0, o_host_out_en);
        apb(1'b0, ad(16, `PSW_OFS_WR_RES), 32'h0);
        // last write result left above is the error code
        chk_data("ready", {29'h0, 1'b1, `PSW_RES_ERR}, rdat);
        i_host_wr_ready <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        apb(1'b0, ad(16, `PSW_OFS_WR_RES), 32'h0);
        chk_data("not ready", {29'h0, 1'b0, `PSW_RES_ERR}, rdat);
        apb(1'b1, ad(16, `PSW_OFS_HPE), 32'h2);
        chk_flag("host in", 1'b0, o_host_in_en);
        chk_flag("host out", 1'b1, o_host_out_en);
        foreach (po[i]) if (i < 2) begin
            apb(1'b0, i ? ad(3, 8) : 18'h0, 32'h0);
            chk_flag("slverr", 1'b1, rerr);
            chk_data("unmapped", 32'h0, rdat);
        end
        finish_test;
    end
endmodule // psw_regs_tb_top
